// File: bench/antenna_supervisor_properties.sv
// checker: port timing of the antenna supervisor
// assumes binding to every antenna_supervisor instance
`default_nettype none
module antenna_supervisor_properties
    import antenna_supervisor_pkg::*;
#(
    parameter longint unsigned RETRY_CYC = RETRY_TIMEOUT_CYC,
    parameter int unsigned SETTLE_CYC = RETEST_SETTLE_CYC
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // config and pins
    input wire logic supply_ctrl_en_i,
    input wire logic short_detect_en_i,
    input wire logic short_retry_en_i,
    input wire logic open_detect_en_i,
    input wire logic short_fault_in_n_i,
    input wire logic presence_sense_in_i,
    // outputs watched
    input wire logic antenna_power_cut_o,
    input wire logic [2:0] link_condition_o,
    input wire logic antenna_power_on_o,
    input wire logic report_valid_o,
    input wire logic [1:0] report_kind_o,
    input wire logic [2:0] report_condition_o,
    input wire logic [FLAG_W-1:0] report_features_o
);
    // =====================================
    // helper: cycles the supply has been cut
    // =====================================
    longint unsigned hi_cnt;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || !antenna_power_cut_o) hi_cnt <= '0;
        else hi_cnt <= hi_cnt + 1;
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // =====================================
    // assertions
    // =====================================
    power_polarity_a: assert property (antenna_power_on_o != antenna_power_cut_o)
        else $error("power status not inverse of cut");
    ctrl_off_a: assert property (!supply_ctrl_en_i [*2] |-> !antenna_power_cut_o)
        else $error("cut driven with supply control off");
    short_cut_a: assert property ($fell(short_fault_in_n_i) && short_detect_en_i && supply_ctrl_en_i
        && link_condition_o != COND_SHORT |-> ##[1:4] antenna_power_cut_o) else $error("short not cut");
    short_status_a: assert property ($rose(antenna_power_cut_o) |-> ##[0:2] link_condition_o == COND_SHORT)
        else $error("cut without short status");
    detect_off_a: assert property (!short_detect_en_i [*8] |-> link_condition_o != COND_SHORT)
        else $error("short seen while detection off");
    open_seen_a: assert property ((open_detect_en_i && !presence_sense_in_i && short_fault_in_n_i
        && !antenna_power_cut_o) [*8] |-> link_condition_o == COND_OPEN) else $error("open not reported");
    open_off_a: assert property (!open_detect_en_i [*4] |-> link_condition_o != COND_OPEN)
        else $error("open seen while detection off");
    change_report_a: assert property (link_condition_o != $past(link_condition_o)
        |-> ##[1:2] report_valid_o && report_kind_o == REPORT_CONDITION) else $error("change unreported");
    no_retry_a: assert property (!short_retry_en_i && short_detect_en_i && antenna_power_cut_o
        |=> antenna_power_cut_o) else $error("retry while retry disabled");
    retry_gap_a: assert property ($fell(antenna_power_cut_o) && short_retry_en_i && short_detect_en_i
        |-> hi_cnt + 3 >= RETRY_CYC && hi_cnt <= RETRY_CYC + 3) else $error("retry period wrong");
    retry_bound_a: assert property (short_retry_en_i |-> hi_cnt <= RETRY_CYC + 3)
        else $error("supply cut too long");
    settle_low_a: assert property ($fell(antenna_power_cut_o) && short_retry_en_i && short_detect_en_i
        |-> !antenna_power_cut_o [*3]) else $error("re-test too short");
    cover property ($rose(antenna_power_cut_o));
    cover property (report_valid_o && report_kind_o == REPORT_FEATURES);
    cover property (link_condition_o == COND_OPEN);
endmodule
bind antenna_supervisor antenna_supervisor_properties #(.RETRY_CYC(RETRY_CYC), .SETTLE_CYC(SETTLE_CYC)) chk (
    .clk_sys_i, .rst_i, .supply_ctrl_en_i, .short_detect_en_i, .short_retry_en_i, .open_detect_en_i,
    .short_fault_in_n_i, .presence_sense_in_i, .antenna_power_cut_o, .link_condition_o, .antenna_power_on_o,
    .report_valid_o, .report_kind_o, .report_condition_o, .report_features_o
);
`default_nettype wire

// File: bench/antenna_supply_model.sv
// partner: antenna supply switch with current sense
// assumes the bench sets whether a short or an antenna is present
`default_nettype none
module antenna_supply_model (
    // from the supervisor
    input wire logic power_cut_i,
    // scenario controls
    input wire logic short_present_i,
    input wire logic antenna_present_i,
    // sense lines
    output logic short_fault_n_o,
    output logic presence_o
);
    // short pulls low only when powered, else pull-up
    assign short_fault_n_o = !(short_present_i && !power_cut_i);
    assign presence_o = antenna_present_i;
endmodule
`default_nettype wire

// File: bench/test_antenna_supervisor.sv
// bench: self-checking scenarios for the antenna supervisor
// assumes package, design, model and checker compiled before
`default_nettype none
module test_antenna_supervisor
    import antenna_supervisor_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RC = 50; // shortened retry period
    logic clk_sys_i = 1'h0;
    logic rst_i = 1'h1;
    logic sup_en = 1'h1;
    logic sd_en = 1'h1;
    logic rt_en = 1'h1;
    logic od_en = 1'h1;
    logic short_on = 1'h0;
    logic ant_on = 1'h1;
    logic sf_n, pres, cut, pwr_on, rv;
    logic [2:0] cond, rc;
    logic [1:0] rk;
    logic [4:0] rf;
    int failures = 0;
    int n_tests = 0;
    antenna_supervisor #(.RETRY_CYC(RC), .SETTLE_CYC(4)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .supply_ctrl_en_i(sup_en), .short_detect_en_i(sd_en), .short_retry_en_i(rt_en),
        .open_detect_en_i(od_en), .short_fault_in_n_i(sf_n), .presence_sense_in_i(pres),
        .antenna_power_cut_o(cut), .link_condition_o(cond), .antenna_power_on_o(pwr_on),
        .report_valid_o(rv), .report_kind_o(rk), .report_condition_o(rc), .report_features_o(rf));
    antenna_supply_model far (.power_cut_i(cut), .short_present_i(short_on), .antenna_present_i(ant_on),
        .short_fault_n_o(sf_n), .presence_o(pres));
    initial forever #5 clk_sys_i = ~clk_sys_i;
    // =====================================
    // shared tasks
    // =====================================
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // wait for the next report pulse, bounded
    task automatic wait_rep(input int lim);
        int i = 0;
        do begin
            @(negedge clk_sys_i);
            i++;
        end while (rv !== 1'h1 && i < lim);
        if (rv !== 1'h1) begin
            failures++;
            results();
        end
    endtask
    // wait for the cut pin to reach a level, bounded
    task automatic wait_cut(input logic v, input int lim);
        int i = 0;
        do begin
            @(negedge clk_sys_i);
            i++;
        end while (cut !== v && i < lim);
        check("cut wait", cut, v);
        // a bound that runs out ends the run
        if (cut !== v) begin
            results();
        end
    endtask
    // =====================================
    // scenarios
    // =====================================
    task automatic startup(input logic [3:0] cfg, input logic [4:0] feat);
        @(negedge clk_sys_i);
        rst_i = 1'h1;
        {sup_en, sd_en, rt_en, od_en} = cfg;
        repeat (20) @(negedge clk_sys_i);
        rst_i = 1'h0;
        wait_rep(10);
        check("kind", rk, REPORT_FEATURES);
        check("features", rf, feat);
        wait_rep(3);
        check("init", rc, COND_INIT);
        wait_rep(6);
        check("eval", rc, COND_OK);
        check("cut", cut, 1'h0);
        check("power", pwr_on, 1'h1);
        $display("test startup done");
    endtask
    task automatic t_short();
        short_on = 1'h1;
        wait_rep(20);
        check("short", rc, COND_SHORT);
        check("power", pwr_on, 1'h0);
        wait_cut(1'h0, RC + 10);
        wait_cut(1'h1, 20);
        check("still", cond, COND_SHORT);
        short_on = 1'h0;
        wait_cut(1'h0, RC + 10);
        wait_rep(20);
        check("clear", rc, COND_OK);
        check("power", pwr_on, 1'h1);
        $display("test short done");
    endtask
    task automatic t_open();
        ant_on = 1'h0;
        wait_rep(20);
        check("open", rc, COND_OPEN);
        ant_on = 1'h1;
        wait_rep(20);
        check("back", rc, COND_OK);
        $display("test open done");
    endtask
    task automatic t_disable();
        od_en = 1'h0;
        ant_on = 1'h0;
        repeat (20) @(negedge clk_sys_i);
        check("open off", cond, COND_OK);
        ant_on = 1'h1;
        od_en = 1'h1;
        sd_en = 1'h0;
        rt_en = 1'h0;
        short_on = 1'h1;
        repeat (20) @(negedge clk_sys_i);
        check("short off", cond, COND_OK);
        sd_en = 1'h1;
        wait_rep(20);
        repeat (RC + 20) @(negedge clk_sys_i);
        check("no retry", cut, 1'h1);
        sd_en = 1'h0;
        wait_cut(1'h0, 20);
        sup_en = 1'h0;
        sd_en = 1'h1;
        repeat (20) @(negedge clk_sys_i);
        check("no ctrl", cond, COND_SHORT);
        check("no ctrl cut", cut, 1'h0);
        short_on = 1'h0;
        sup_en = 1'h1;
        rt_en = 1'h1;
        $display("test disable done");
    endtask
    initial begin
        startup({CFG_SUPPLY_RST, CFG_SHORT_RST, CFG_RETRY_RST, CFG_OPEN_RST}, 5'h1f);
        t_short();
        t_open();
        t_disable();
        startup(4'hc, 5'h0b);
        results();
    end
endmodule
`default_nettype wire

// File: hdl/antenna_supervisor.sv
// antenna supervisor: short/open detection, supply cut and timed short retry
// assumes sense pins are asynchronous; config bits come from local logic on clk_sys_i
//
// Contract
// - supply control bit enables power cut output
// - power cut output active low powers supply
// - all features enabled out of reset
// - short detection only while short_detect_en
// - low short input means short, cut supply
// - undriven short input reads high, no short
// - status shows short/off (short/on with supply control off or during re-test) or ok/on
// - automatic recovery only while short_retry_en
// - after timeout reconnect supply and re-test
// - clean re-test reports ok, power on
// - failed re-test cuts again, retries again
// - open detection only while open_detect_en
// - high presence input means antenna connected
// - low presence input reports open
// - floating or high presence reports ok
// - startup: features report, init, then status
// - feature report carries one flag each
// - status changes delivered as reports
`default_nettype none

module antenna_supervisor
    import antenna_supervisor_pkg::*;
#(
    parameter longint unsigned RETRY_CYC = RETRY_TIMEOUT_CYC,
    parameter int unsigned SETTLE_CYC = RETEST_SETTLE_CYC
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // configuration bits (held externally, reset value is all ones)
    // defaults all on
    input wire logic supply_ctrl_en_i,
    input wire logic short_detect_en_i,
    input wire logic short_retry_en_i,
    input wire logic open_detect_en_i,
    // antenna sense pins
    input wire logic short_fault_in_n_i,
    input wire logic presence_sense_in_i,
    // supply control pin
    output logic antenna_power_cut_o,
    // readable status
    output logic [2:0] link_condition_o,
    output logic antenna_power_on_o,
    // report stream to host formatter
    output logic report_valid_o,
    output logic [1:0] report_kind_o,
    output logic [2:0] report_condition_o,
    output logic [FLAG_W-1:0] report_features_o
);

    // =========================================================
    // types
    // =========================================================
    typedef enum logic [2:0] {
        ST_BOOT = 3'b000,
        ST_FEAT = 3'b001,
        ST_INIT = 3'b010,
        ST_RUN = 3'b011,
        ST_CUT = 3'b100,
        ST_RETEST = 3'b101
    } state_e;

    localparam int unsigned CNT_W = 48;

    // =========================================================
    // signals
    // =========================================================
    logic [1:0] sense_sync_v; // synchronised {presence, short_n}
    logic short_n; // synchronised short input, high means no short
    logic present; // synchronised presence input
    logic short_seen; // qualified short condition
    state_e state;
    state_e next_state;
    logic [CNT_W-1:0] timer; // retry and settle counter
    logic [2:0] cond; // evaluated link condition
    logic [2:0] next_cond;
    logic [2:0] reported; // last condition reported
    logic cut; // internal supply cut request

    // returns the feature flag vector for the current configuration
    function automatic logic [FLAG_W-1:0] feature_flags(input logic sup, input logic shd,
                                                       input logic opd, input logic rec);
        logic [FLAG_W-1:0] f;
        f = '0;
        f[FLAG_SUPPLY] = sup;
        f[FLAG_SHORT] = shd;
        f[FLAG_OPEN] = opd;
        // power-down on short needs both supply control and short detection
        f[FLAG_PDOWN] = sup & shd;
        f[FLAG_RECOV] = rec & sup & shd;
        return f;
    endfunction

    // =========================================================
    // input synchronisation
    // =========================================================
    // two-flop sync
    sense_sync #(
        .W(2),
        .RST_VAL(2'h3)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .async_i({presence_sense_in_i, short_fault_in_n_i}),
        .sync_o(sense_sync_v)
    );

    assign short_n = sense_sync_v[0];
    assign present = sense_sync_v[1];

    assign short_seen = short_detect_en_i & ~short_n;

    // =========================================================
    // supervisor state machine
    // =========================================================
    always_comb begin
        next_state = state;
        case (state)
            // one cycle after reset: emit feature list
            ST_BOOT: begin
                next_state = ST_FEAT;
            end
            // then the init condition
            ST_FEAT: begin
                next_state = ST_INIT;
            end
            // then evaluated condition
            ST_INIT: begin
                next_state = ST_RUN;
            end
            // normal watch
            ST_RUN: begin
                if (short_seen) begin
                    next_state = ST_CUT;
                end
            end
            // supply cut, waiting for retry timeout
            ST_CUT: begin
                if (!short_detect_en_i) begin
                    next_state = ST_RUN;
                end else if (short_retry_en_i && timer >= CNT_W'(RETRY_CYC - 1)) begin
                    next_state = ST_RETEST;
                end
            end
            // supply on again, settle then re-sample
            ST_RETEST: begin
                if (timer >= CNT_W'(SETTLE_CYC - 1)) begin
                    next_state = short_seen ? ST_CUT : ST_RUN;
                end
            end
            default: begin
                next_state = ST_BOOT;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state <= ST_BOOT;
        end else begin
            state <= next_state;
        end
    end

    // timer restarts on each state change
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            timer <= '0;
        end else if (next_state != state) begin
            timer <= '0;
        end else if (state == ST_CUT || state == ST_RETEST) begin
            timer <= timer + CNT_W'(1);
        end
    end

    // =========================================================
    // link condition evaluation
    // =========================================================
    always_comb begin
        next_cond = COND_OK;
        if (state == ST_BOOT || state == ST_FEAT) begin
            next_cond = COND_INIT;
        end else if (state == ST_CUT) begin
            next_cond = COND_SHORT;
        end else if (state == ST_RETEST) begin
            // keep short until re-test decides
            next_cond = COND_SHORT;
        end else if (short_seen && state == ST_RUN) begin
            next_cond = COND_SHORT;
        end else if (open_detect_en_i && !present) begin
            next_cond = COND_OPEN;
        end else begin
            next_cond = COND_OK;
        end
    end

    // condition register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cond <= COND_INIT;
        end else begin
            cond <= next_cond;
        end
    end

    // =========================================================
    // supply cut control
    // =========================================================
    // only drives when enabled
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cut <= 1'b0;
        end else begin
            cut <= supply_ctrl_en_i & (next_state == ST_CUT);
        end
    end

    assign antenna_power_cut_o = cut;

    assign link_condition_o = cond;
    assign antenna_power_on_o = ~cut;

    // =========================================================
    // report generation
    // =========================================================
    // feature, init, then status
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            report_valid_o <= 1'b0;
            report_kind_o <= 2'h0;
            report_condition_o <= COND_INIT;
            report_features_o <= '0;
            reported <= COND_INIT;
        end else begin
            report_valid_o <= 1'b0;
            if (state == ST_FEAT) begin
                report_valid_o <= 1'b1;
                report_kind_o <= REPORT_FEATURES;
                report_features_o <= feature_flags(supply_ctrl_en_i, short_detect_en_i,
                                                   open_detect_en_i, short_retry_en_i);
            end else if (state == ST_INIT) begin
                report_valid_o <= 1'b1;
                report_kind_o <= REPORT_CONDITION;
                report_condition_o <= COND_INIT;
                reported <= COND_INIT;
            end else if (state != ST_BOOT && cond != reported) begin
                report_valid_o <= 1'b1;
                report_kind_o <= REPORT_CONDITION;
                report_condition_o <= cond;
                reported <= cond;
            end
        end
    end

endmodule

`default_nettype wire

// File: hdl/antenna_supervisor_pkg.sv
// package: status codes, report codes, feature flag positions and timing counts
// assumes a 100 MHz system clock
`default_nettype none

package antenna_supervisor_pkg;

    // =========================================================
    // clock and timing
    // =========================================================
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned RETRY_TIMEOUT_S = 30;
    localparam longint unsigned RETRY_TIMEOUT_CYC = longint'(RETRY_TIMEOUT_S) * longint'(CLK_HZ);
    // cycles the supply stays on before the re-test samples the short input
    localparam int unsigned RETEST_SETTLE_CYC = 4;

    // =========================================================
    // link condition codes
    // =========================================================
    localparam logic [2:0] COND_INIT = 3'h0;
    localparam logic [2:0] COND_OK = 3'h1;
    localparam logic [2:0] COND_SHORT = 3'h2;
    localparam logic [2:0] COND_OPEN = 3'h3;

    // =========================================================
    // report kinds
    // =========================================================
    localparam logic [1:0] REPORT_FEATURES = 2'h1;
    localparam logic [1:0] REPORT_CONDITION = 2'h2;

    // =========================================================
    // feature list flag positions
    // =========================================================
    localparam int unsigned FLAG_SUPPLY = 0;
    localparam int unsigned FLAG_SHORT = 1;
    localparam int unsigned FLAG_OPEN = 2;
    localparam int unsigned FLAG_PDOWN = 3;
    localparam int unsigned FLAG_RECOV = 4;
    localparam int unsigned FLAG_W = 5;

    // =========================================================
    // configuration reset values (all on)
    // =========================================================
    localparam logic CFG_SUPPLY_RST = 1'h1;
    localparam logic CFG_SHORT_RST = 1'h1;
    localparam logic CFG_RETRY_RST = 1'h1;
    localparam logic CFG_OPEN_RST = 1'h1;

endpackage

`default_nettype wire

// File: hdl/sense_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes inputs are asynchronous to clk_sys_i
`default_nettype none

module sense_sync #(
    parameter int unsigned W = 2,
    parameter logic [W-1:0] RST_VAL = '1
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // pins
    input wire logic [W-1:0] async_i,
    // synchronised levels
    output logic [W-1:0] sync_o
);

    logic [W-1:0] meta; // first stage, read only by second stage

    // =========================================================
    // two stage capture
    // =========================================================
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            meta <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end

endmodule

`default_nettype wire
